/* File: slof_consts.svh */
// Register offsets, field positions and reset values of the lane framer.
// Assumes inclusion by bare name from packages or modules that need it.
`ifndef SLOF_CONSTS_SVH
`define SLOF_CONSTS_SVH

// Byte addresses on the register bus
`define SLOF_CTRL_ADDR 32'h0000_0000
`define SLOF_STAT_ADDR 32'h0000_0004
// Printed index of the lane PLL rate-band register; byte address is 4x
`define SLOF_PLL_IDX 32'h0000_056E
`define SLOF_PLL_ADDR (`SLOF_PLL_IDX << 2)

// Reset values
`define SLOF_CTRL_RST 32'h0000_0000
`define SLOF_PLL_RST 8'h00

// Control field positions
`define SLOF_EN_BIT 0
`define SLOF_MODE_LO 1
`define SLOF_MODE_HI 2
`define SLOF_LLOG_LO 4
`define SLOF_LLOG_HI 5
`define SLOF_MLOG_LO 6
`define SLOF_MLOG_HI 7
`define SLOF_FLOG_LO 8
`define SLOF_FLOG_HI 10
`define SLOF_KM1_LO 16
`define SLOF_KM1_HI 20
`define SLOF_DCM_LO 24
`define SLOF_DCM_HI 31

// Multiframe sizing and per-lane rate factor
`define SLOF_KF_ALIGN 4
`define SLOF_KMIN_F1 6'd20
`define SLOF_KMIN_F2 6'd12
`define SLOF_KMIN_F4 6'd8
`define SLOF_KMIN_FX 6'd4
`define SLOF_FLOG_MAX 3'd4
`define SLOF_RATE_X2 8'd20

`endif

/* File: slof_pkg.sv */
// Types shared by the lane framer files.
// Assumes nothing beyond a SystemVerilog compiler.
package slof_pkg;

  // Application modes; mode_full_bw and mode_two_ddc fix the virtual converter count
  typedef enum logic [1:0] {
    mode_generic,
    mode_full_bw,
    mode_two_ddc,
    mode_reserved
  } slof_mode_e;

endpackage

/* File: slof_pair_buf.sv */
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module slof_pair_buf #(
  parameter int W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  logic [W-1:0] head; // Oldest word, drives the output directly
  logic [W-1:0] spare; // Second word while the reader stalls
  logic [1:0] cnt; // Words held, 0 to 2
  logic [W-1:0] next_head;
  logic [W-1:0] next_spare;
  logic [1:0] next_cnt;
  logic put;
  logic pop;

  // Full only at two words, so one more word still fits after the reader stalls
  assign in_ready = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data = head;
  assign put = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next contents; head is refilled from spare so order is kept
  always_comb begin
    next_head = head;
    next_spare = spare;
    next_cnt = cnt + {1'b0, put} - {1'b0, pop};
    if (put && (cnt == 2'h0 || (cnt == 2'h1 && pop))) begin
      next_head = in_data;
    end else if (put) begin
      next_spare = in_data;
    end
    if (pop && cnt == 2'h2) begin
      next_head = spare;
    end
  end

  // Registers only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      head <= '0;
      spare <= '0;
      cnt <= 2'h0;
    end else begin
      head <= next_head;
      spare <= next_spare;
      cnt <= next_cnt;
    end
  end

  buf_bound_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cnt <= 2'h2) else $error("buffer count above two");
  buf_stall_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
    else $error("stalled output word changed");

endmodule

/* File: slof_framer.sv */
// Transport framer for 8-bit sample words with an AHB-Lite register slave.
// Assumes samples arrive on hclk with valid/ready and the lane serialiser
// downstream consumes octets tagged with lane and frame markers.
`timescale 1ns/1ps
`include "slof_consts.svh"

module slof_framer import slof_pkg::*; #(
  parameter int CNT_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [7:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready,
  output logic [7:0] octet_data,
  output logic [2:0] octet_lane,
  output logic octet_frame_start,
  output logic octet_mf_start,
  output logic octet_valid,
  input wire logic octet_ready
);

  // Register state
  logic [31:0] ctrl; // Link configuration and enable
  logic [7:0] pll_band; // Lane PLL rate band, steers nothing here
  logic wr_pend; // Write data phase pending
  logic [31:0] wr_addr; // Address captured in the write's address phase
  logic [31:0] next_ctrl;
  logic [7:0] next_pll_band;
  logic next_wr_pend;
  logic [31:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic addr_ok;

  // Decoded configuration
  slof_mode_e mode;
  logic [1:0] l_log2;
  logic [1:0] m_log2; // Effective converter count as log2
  logic [2:0] f_log2;
  logic [4:0] k_m1;
  logic [7:0] chip_decimation_ratio;
  logic [5:0] f_oct;
  logic [5:0] k_frames;
  logic [11:0] kf;
  logic [5:0] k_min;
  logic [7:0] rate_x2; // Lane rate over output rate, times two
  logic cfg_err;
  logic running;

  // Framing state
  logic [7:0] dec_cnt;
  logic [4:0] oct;
  logic [2:0] lane;
  logic [4:0] frame;
  logic [CNT_W-1:0] mf_count;
  logic [7:0] next_dec_cnt;
  logic [4:0] next_oct;
  logic [2:0] next_lane;
  logic [4:0] next_frame;
  logic [CNT_W-1:0] next_mf_count;
  logic take;
  logic push;
  logic oct_last;
  logic lane_last;
  logic buf_in_ready;
  logic [12:0] buf_in;
  logic [12:0] buf_out;

  // Zero-wait slave that never errors
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel & hready & htrans[1];

  // Field decode; the two fixed modes override the converter count
  assign mode = slof_mode_e'(ctrl[`SLOF_MODE_HI:`SLOF_MODE_LO]);
  assign l_log2 = ctrl[`SLOF_LLOG_HI:`SLOF_LLOG_LO];
  assign f_log2 = ctrl[`SLOF_FLOG_HI:`SLOF_FLOG_LO];
  assign k_m1 = ctrl[`SLOF_KM1_HI:`SLOF_KM1_LO];
  assign chip_decimation_ratio = ctrl[`SLOF_DCM_HI:`SLOF_DCM_LO];
  always_comb begin
    case (mode)
      mode_full_bw: m_log2 = 2'h1;
      mode_two_ddc: m_log2 = 2'h2;
      default: m_log2 = ctrl[`SLOF_MLOG_HI:`SLOF_MLOG_LO];
    endcase
  end

  // Per-lane rate factor, doubled to keep the 2.5 case whole
  assign rate_x2 = (`SLOF_RATE_X2 << m_log2) >> l_log2;

  // Multiframe sizing, decimation and mode check; a bad setting keeps the link stopped
  assign f_oct = 6'h01 << f_log2;
  assign k_frames = {1'b0, k_m1} + 6'h01;
  assign kf = {6'h00, k_frames} * {6'h00, f_oct};
  always_comb begin
    case (f_log2)
      3'h0: k_min = `SLOF_KMIN_F1;
      3'h1: k_min = `SLOF_KMIN_F2;
      3'h2: k_min = `SLOF_KMIN_F4;
      default: k_min = `SLOF_KMIN_FX;
    endcase
  end
  assign cfg_err = (f_log2 > `SLOF_FLOG_MAX)
    || (kf % `SLOF_KF_ALIGN != 0) || (k_frames < k_min)
    || (chip_decimation_ratio == 8'h00) || (mode == mode_reserved);
  assign running = ctrl[`SLOF_EN_BIT] & ~cfg_err;

  // Bus next values; control and band reads see a write that lands in the same cycle
  always_comb begin
    next_wr_pend = addr_ok & hwrite;
    next_wr_addr = haddr;
    next_ctrl = ctrl;
    next_pll_band = pll_band;
    next_hrdata = hrdata;
    if (wr_pend) begin
      case (wr_addr)
        `SLOF_CTRL_ADDR: next_ctrl = hwdata;
        `SLOF_PLL_ADDR: next_pll_band = hwdata[7:0];
        default: ; // Unmapped writes are dropped
      endcase
    end
    if (addr_ok && !hwrite) begin
      case (haddr)
        `SLOF_CTRL_ADDR: next_hrdata = next_ctrl;
        `SLOF_STAT_ADDR: next_hrdata = {mf_count, rate_x2, 6'h00,
                                        running, cfg_err};
        `SLOF_PLL_ADDR: next_hrdata = {24'h000000, next_pll_band};
        default: next_hrdata = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `SLOF_CTRL_RST;
      pll_band <= `SLOF_PLL_RST;
      wr_pend <= 1'b0;
      wr_addr <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      pll_band <= next_pll_band;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
    end
  end

  // Decimation: only every dcm-th sample enters the frame
  assign sample_ready = running & (buf_in_ready | (dec_cnt != 8'h00));
  assign take = sample_valid & sample_ready;
  assign push = take & (dec_cnt == 8'h00);
  assign oct_last = ({1'b0, oct} == f_oct - 6'h01);
  assign lane_last = (lane == 3'((4'h1 << l_log2) - 4'h1));

  // Octet, lane and frame counters; octets fill a lane before the next
  always_comb begin
    next_dec_cnt = dec_cnt;
    next_oct = oct;
    next_lane = lane;
    next_frame = frame;
    next_mf_count = mf_count;
    if (!running) begin
      // Stopping restarts the multiframe so a new setup aligns cleanly
      next_dec_cnt = 8'h00;
      next_oct = 5'h00;
      next_lane = 3'h0;
      next_frame = 5'h00;
    end else begin
      if (take) begin
        next_dec_cnt = (dec_cnt == chip_decimation_ratio - 8'h01) ? 8'h00 : dec_cnt + 8'h01;
      end
      if (push) begin
        if (!oct_last) begin
          next_oct = oct + 5'h01;
        end else begin
          next_oct = 5'h00;
          if (!lane_last) begin
            next_lane = lane + 3'h1;
          end else begin
            next_lane = 3'h0;
            if (frame == k_m1) begin
              next_frame = 5'h00;
              next_mf_count = mf_count + CNT_W'(1);
            end else begin
              next_frame = frame + 5'h01;
            end
          end
        end
      end
    end
  end

  // Framing registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_cnt <= 8'h00;
      oct <= 5'h00;
      lane <= 3'h0;
      frame <= 5'h00;
      mf_count <= '0;
    end else begin
      dec_cnt <= next_dec_cnt;
      oct <= next_oct;
      lane <= next_lane;
      frame <= next_frame;
      mf_count <= next_mf_count;
    end
  end

  // Tag each octet with its lane and frame markers on the way in
  assign buf_in = {(oct == 5'h00) && (lane == 3'h0) && (frame == 5'h00),
                   (oct == 5'h00) && (lane == 3'h0), lane, sample_data};
  assign {octet_mf_start, octet_frame_start, octet_lane, octet_data} =
    buf_out;

  // Absorbs a receiver stall so no word is lost
  slof_pair_buf #(.W(13)) u_buf (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_data(buf_in),
    .in_valid(push),
    .in_ready(buf_in_ready),
    .out_data(buf_out),
    .out_valid(octet_valid),
    .out_ready(octet_ready)
  );

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  bus_read_a: assert property (
    (addr_ok && !hwrite && haddr == `SLOF_PLL_ADDR && !wr_pend)
    |=> hrdata == {24'h000000, pll_band})
    else $error("band register read mismatch");
  // Each taken sample short of the wrap moves the decimation count by one
  dec_step_a: assert property (
    (running && take && dec_cnt != chip_decimation_ratio - 8'h01)
    |=> dec_cnt == $past(dec_cnt) + 8'h01)
    else $error("decimation counter did not step");
  dec_turn_a: assert property (
    (running && take && dec_cnt == chip_decimation_ratio - 8'h01) |=> dec_cnt == 8'h00)
    else $error("decimation counter did not wrap");
  // Checked through the rate factor so a wrong override shows up
  full_bw_a: assert property (
    (mode == mode_full_bw && l_log2 == 2'h2) |-> rate_x2 == 8'd10)
    else $error("full bandwidth not two converters");
  two_ddc_a: assert property (
    (mode == mode_two_ddc && l_log2 == 2'h1) |-> rate_x2 == 8'd40)
    else $error("two downconverter not four converters");
  rate_factor_a: assert property (
    (m_log2 == 2'h0 && l_log2 == 2'h2) |-> rate_x2 == 8'd5)
    else $error("lane rate factor wrong");
  kf_legal_a: assert property (
    running |-> (kf[1:0] == 2'h0 && k_frames >= k_min))
    else $error("link running with illegal multiframe");
  frame_wrap_a: assert property (
    (running && push && oct_last && lane_last && frame == k_m1)
    |=> (frame == 5'h00 && oct == 5'h00 && lane == 3'h0))
    else $error("multiframe did not wrap after K frames");
  octet_step_a: assert property (
    (running && push && !oct_last) |=> oct == $past(oct) + 5'h01)
    else $error("octet index did not advance");

  mf_wrap_c: cover property (push && oct_last && lane_last
                             && frame == k_m1);
  stall_c: cover property (octet_valid && !octet_ready ##1
                           !buf_in_ready);
  cfg_err_c: cover property (ctrl[`SLOF_EN_BIT] && cfg_err);
  ddc_run_c: cover property (running && mode == mode_two_ddc && push);

endmodule

/* File: slof_rx_model.sv */
// Octet sink standing in for the link receiver at the framer's far side.
// Assumes one clock shared with the framer and an active-low reset.
`timescale 1ns/1ps
module slof_rx_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic octet_valid,
  output logic octet_ready
);
  // Ready drops at random one cycle in four, so the buffer must hold words
  // across stalls; a real receiver can back-pressure just as unkindly
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      octet_ready <= 1'b0;
    end else begin
      octet_ready <= ($urandom % 4) != 0;
    end
  end
endmodule

/* File: serial_link_output_config_test.sv */
// Self-checking bench for the lane framer: registers over AHB-Lite and the
// octet stream. Assumes the framer has one slave on the bus.
`timescale 1ns/1ps
`include "slof_consts.svh"
module serial_link_output_config_test import slof_pkg::*;;
  typedef struct packed {
    logic [7:0] d;
    logic [2:0] l;
    logic fs;
    logic ms;
  } slof_exp_s;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hready;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize, octet_lane;
  logic [7:0] sample_data, octet_data;
  logic sample_valid, sample_ready, octet_valid, octet_ready;
  logic octet_frame_start, octet_mf_start;
  int fail_count = 0;
  int tests_run = 0;
  slof_exp_s expq[$]; // Expected octets in order
  assign hready = hreadyout; // Single slave drives the bus ready
  slof_framer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .octet_data(octet_data), .octet_lane(octet_lane),
    .octet_frame_start(octet_frame_start), .octet_mf_start(octet_mf_start),
    .octet_valid(octet_valid), .octet_ready(octet_ready));
  slof_rx_model rx (.hclk(hclk), .hresetn(hresetn),
    .octet_valid(octet_valid), .octet_ready(octet_ready));
  // Free-running 200 MHz clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Verdict and end of run
  task automatic close_out;
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Word comparison
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Octet comparison, data and markers together
  task automatic chk_oct(input slof_exp_s got, input slof_exp_s exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One single AHB transfer; waits on hready under a bound
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    int n = 0;
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= a;
    htrans <= 2'b10;
    do @(posedge hclk); while (!hready && ++n < 50);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (!hready && ++n < 100);
    r = hrdata;
    chk32({31'h0, hresp}, 32'h0);
    if (n >= 50) begin
      fail_count++;
      close_out();
    end
  endtask
  // Control word: enable always set, fields packed at their positions
  function automatic logic [31:0] cfg(input slof_mode_e md, input int ll,
      input int ml, input int fl, input int k, input int dc);
    return {8'(dc), 3'h0, 5'(k - 1), 5'h0, 3'(fl), 2'(ml), 2'(ll), 1'b0,
            md, 1'b1};
  endfunction
  // Configure, then check rate factor, running and error bits
  task automatic cfg_chk(input slof_mode_e md, input int ll, input int ml,
      input int fl, input int k, input int dc, input logic [7:0] rate,
      input logic [1:0] st);
    bus(1'b1, `SLOF_CTRL_ADDR, 32'h0);
    bus(1'b1, `SLOF_CTRL_ADDR, cfg(md, ll, ml, fl, k, dc));
    bus(1'b0, `SLOF_STAT_ADDR, 32'h0);
    chk32(r & 32'h0000FF03, {16'h0, rate, 6'h0, st});
    chk32({31'h0, sample_ready}, {31'h0, st[1]});
  endtask
  // Feed random samples until cnt words are kept; note what must come out
  task automatic stream(input int cnt, input int dc, input int f,
                        input int l, input int k);
    int kept = 0;
    int taken = 0;
    int cyc = 0;
    int p;
    logic tk;
    slof_exp_s e;
    while (kept < cnt && cyc < 5000) begin
      sample_valid <= ($urandom % 4) != 0;
      sample_data <= 8'($urandom);
      @(negedge hclk);
      tk = sample_valid & sample_ready;
      if (tk && taken % dc == 0) begin
        p = kept % (f * l);
        e = '{sample_data, 3'(p / f), p == 0,
              p == 0 && (kept / (f * l)) % k == 0};
        expq.push_back(e);
        kept++;
      end
      if (tk) begin
        taken++;
      end
      @(posedge hclk);
      cyc++;
    end
    sample_valid <= 1'b0;
    while (expq.size() != 0 && cyc < 6000) begin
      @(posedge hclk);
      cyc++;
    end
    if (cyc >= 5000) begin
      fail_count++;
      close_out();
    end
  endtask
  // Watcher: every octet taken is matched with the oldest note
  always @(negedge hclk) begin
    if (hresetn && octet_valid && octet_ready) begin
      if (expq.size() == 0) begin
        chk32(32'h1, 32'h0);
      end else begin
        chk_oct({octet_data, octet_lane, octet_frame_start,
                 octet_mf_start}, expq.pop_front());
      end
    end
  end
  // Main sequence
  initial begin
    void'($urandom(32'hF11D69CE));
    hresetn = 1'b0;
    {hsel, hwrite, sample_valid} = 3'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    sample_data = 8'h00;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, `SLOF_CTRL_ADDR, 32'h0);
    chk32(r, `SLOF_CTRL_RST);
    bus(1'b0, `SLOF_PLL_ADDR, 32'h0);
    chk32(r, {24'h0, `SLOF_PLL_RST});
    bus(1'b1, `SLOF_PLL_ADDR, 32'h30);
    bus(1'b0, `SLOF_PLL_ADDR, 32'h0);
    chk32(r, 32'h30);
    bus(1'b1, `SLOF_PLL_ADDR, 32'h10);
    bus(1'b0, `SLOF_PLL_ADDR, 32'h0);
    chk32(r, 32'h10);
    // Unmapped place: write is ignored, read gives zero
    bus(1'b1, 32'h0000_0100, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_0100, 32'h0);
    chk32(r, 32'h0);
    cfg_chk(mode_full_bw, 2, 0, 0, 20, 1, 8'd10, 2'b10);
    cfg_chk(mode_two_ddc, 1, 0, 2, 8, 4, 8'd40, 2'b10);
    cfg_chk(mode_generic, 2, 0, 0, 16, 1, 8'd5, 2'b01);
    cfg_chk(mode_generic, 0, 0, 1, 13, 1, 8'd20, 2'b01);
    cfg_chk(mode_generic, 0, 0, 3, 4, 1, 8'd20, 2'b10);
    cfg_chk(mode_generic, 0, 0, 5, 4, 1, 8'd20, 2'b01);
    cfg_chk(mode_generic, 0, 0, 0, 20, 0, 8'd20, 2'b01);
    cfg_chk(mode_reserved, 0, 0, 0, 20, 1, 8'd20, 2'b01);
    // Eight lanes, four converters: generic converter field is honoured
    cfg_chk(mode_generic, 3, 2, 0, 20, 1, 8'd10, 2'b10);
    // Two lanes, two octets a frame, shortest legal multiframe, halved rate
    cfg_chk(mode_generic, 1, 0, 1, 12, 2, 8'd10, 2'b10);
    stream(100, 2, 2, 2, 12);
    // Restart from a stopped link with one lane and decimation by three
    cfg_chk(mode_generic, 0, 0, 2, 8, 3, 8'd20, 2'b10);
    stream(70, 3, 4, 1, 8);
    // Whole multiframes so far: 100 / (2*2*12) plus 70 / (4*1*8)
    bus(1'b0, `SLOF_STAT_ADDR, 32'h0);
    chk32({16'h0, r[31:16]}, 32'd4);
    close_out();
  end
endmodule
